// *** hw/mesh_frame_relay_logic.sv ***
/*
 * Mesh frame relay engine: originates, relays and delivers mesh frames,
 * filters broadcast copies, raises immediate acknowledgements and
 * retransmit requests. Assumes the framer, the relaying database and
 * the upper entity all run on ref_clk and hold inputs until handshaked.
 */
`timescale 1ns/1ns
module mesh_frame_relay_logic (
	input  wire logic                           ref_clk,
	input  wire logic                           rst_n,
	input  wire logic [mesh_relay_pkg::ID_W-1:0]  ownId,
	input  wire logic                           relayEnable,
	input  wire logic                           isRelay,
	input  wire logic                           isBcastRelay,
	input  wire logic [mesh_relay_pkg::HOP_W-1:0] maxHops,
	input  wire logic                           rxValid,
	output wire logic                           rxReady,
	input  wire logic                           rxMesh,
	input  wire logic [mesh_relay_pkg::ID_W-1:0]  rxSrcNode,
	input  wire logic [mesh_relay_pkg::ID_W-1:0]  rxDstNode,
	input  wire logic [mesh_relay_pkg::ID_W-1:0]  rxOrigAddr,
	input  wire logic [mesh_relay_pkg::ID_W-1:0]  rxFinalAddr,
	input  wire logic [mesh_relay_pkg::HOP_W-1:0] rxHopsLeft,
	input  wire logic [mesh_relay_pkg::FID_W-1:0] rxFid,
	input  wire logic                           rxAckReq,
	input  wire logic                           rxAckType,
	input  wire logic                           rxCrcOk,
	input  wire logic [mesh_relay_pkg::MAP_W-1:0] rxErrMap,
	input  wire logic                           origValid,
	output wire logic                           origReady,
	input  wire logic                           origMulti,
	input  wire logic                           origBcast,
	input  wire logic [mesh_relay_pkg::ID_W-1:0]  origDest,
	input  wire logic [mesh_relay_pkg::FID_W-1:0] origFid,
	input  wire logic                           origAckReq,
	input  wire logic                           origAckType,
	output logic                                origRefused,
	output wire logic                           lkReq,
	output wire logic                           lkBcast,
	output wire logic [mesh_relay_pkg::ID_W-1:0]  lkSrcNode,
	output wire logic [mesh_relay_pkg::ID_W-1:0]  lkOrigAddr,
	output wire logic [mesh_relay_pkg::ID_W-1:0]  lkFinalAddr,
	input  wire logic                           lkAck,
	input  wire logic                           lkSenderOk,
	input  wire logic                           lkPathOk,
	input  wire logic [mesh_relay_pkg::ID_W-1:0]  lkNextHop,
	input  wire logic                           lkUseBcast,
	output wire logic                           upValid,
	input  wire logic                           upReady,
	output wire logic [mesh_relay_pkg::ID_W-1:0]  upSrcNode,
	output wire logic [mesh_relay_pkg::ID_W-1:0]  upOrigAddr,
	output wire logic [mesh_relay_pkg::ID_W-1:0]  upFinalAddr,
	output wire logic [mesh_relay_pkg::FID_W-1:0] upFid,
	output wire logic                           upMesh,
	output wire logic                           txValid,
	input  wire logic                           txReady,
	output wire mesh_relay_pkg::txd_t           txHeader,
	output logic                                ackSend,
	output logic                                ackKind,
	output logic                                ackOk,
	output logic [mesh_relay_pkg::MAP_W-1:0]      ackMap,
	output logic [mesh_relay_pkg::ID_W-1:0]       ackDest,
	input  wire logic                           ackInValid,
	input  wire logic                           ackInKind,
	input  wire logic                           ackInOk,
	input  wire logic [mesh_relay_pkg::MAP_W-1:0] ackInMap,
	output logic                                retxValid,
	output logic                                retxWhole,
	output logic [mesh_relay_pkg::MAP_W-1:0]      retxMap,
	output logic                                dropPulse
);
	import mesh_relay_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	state_t           state_r, state_nxt;
	txd_t             hdr_r, hdr_nxt;
	logic             isOrig_r, isOrig_nxt;
	logic             txFlag_r, txFlag_nxt;
	logic [HOP_W-1:0] rxHops_r, rxHops_nxt;
	logic [ID_W-1:0]  upSrc_r, upSrc_nxt;
	logic             drop_nxt, refused_nxt, ackSend_nxt, ackKind_nxt, ackOk_nxt;
	logic [MAP_W-1:0] ackMap_nxt, retxMap_nxt;
	logic [ID_W-1:0]  ackDest_nxt, nextDst;
	logic             retxValid_nxt, retxWhole_nxt;
	logic             chkOk, doRelay, doDeliver, dupHit, dupRec, push;
	logic [ID_W-1:0]  dupOrig_r [DUP_N], dupOrig_nxt [DUP_N];
	logic [FID_W-1:0] dupFid_r [DUP_N], dupFid_nxt [DUP_N];
	logic [DUP_N-1:0] dupVld_r, dupVld_nxt;
	logic [1:0]       dupPtr_r, dupPtr_nxt;

	fifo_if #(.W(TXD_W)) fifoIf ();
	relay_fifo #(.WIDTH(TXD_W), .DEPTH(FIFO_DEPTH)) u_relay_fifo (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.q       (fifoIf.store)
	);

	// ****************************************
	// Handshakes and lookup port
	// ****************************************
	assign rxReady = (state_r == ST_IDLE);
	assign origReady = (state_r == ST_IDLE) && !rxValid;
	assign lkReq = (state_r == ST_LOOK);
	assign lkBcast = (hdr_r.finalAddr == ALL_NODES);
	assign lkSrcNode = hdr_r.srcNode;
	assign lkOrigAddr = hdr_r.origAddr;
	assign lkFinalAddr = hdr_r.finalAddr;
	assign upValid = (state_r == ST_UP);
	assign upSrcNode = upSrc_r;
	assign upOrigAddr = hdr_r.origAddr;
	assign upFinalAddr = hdr_r.finalAddr;
	assign upFid = hdr_r.fid;
	assign upMesh = (hdr_r.addrMode == MODE_SHORT);
	assign fifoIf.inVal = (state_r == ST_TX);
	assign fifoIf.inData = hdr_r;
	assign fifoIf.outRdy = txReady;
	assign txValid = fifoIf.outVal;
	assign txHeader = txd_t'(fifoIf.outData);
	assign push = fifoIf.inVal && fifoIf.inRdy;

	// Database may answer with a broadcast hop instead of a next node
	assign nextDst = (lkBcast && lkUseBcast) ? ALL_NODES : lkNextHop;
	assign chkOk = lkSenderOk && lkPathOk;
	assign doDeliver = lkBcast && chkOk && !dupHit;
	assign doRelay = relayEnable && chkOk && (hdr_r.hopsLeft != '0)
		&& (lkBcast ? (isBcastRelay && !dupHit) : isRelay);

	// ****************************************
	// Broadcast copy filter
	// ****************************************
	always_comb begin
		dupHit = 1'b0;
		for (int i = 0; i < DUP_N; i++) begin
			if (dupVld_r[i] && dupOrig_r[i] == hdr_r.origAddr && dupFid_r[i] == hdr_r.fid) begin
				dupHit = 1'b1;
			end
		end
	end
	// Round-robin replacement; only a few recent floods are remembered
	always_comb begin
		dupOrig_nxt = dupOrig_r;
		dupFid_nxt = dupFid_r;
		dupVld_nxt = dupVld_r;
		dupPtr_nxt = dupPtr_r;
		if (dupRec) begin
			dupOrig_nxt[dupPtr_r] = hdr_r.origAddr;
			dupFid_nxt[dupPtr_r] = hdr_r.fid;
			dupVld_nxt[dupPtr_r] = 1'b1;
			dupPtr_nxt = dupPtr_r + 2'h1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dupOrig_r <= '{default: '0};
			dupFid_r <= '{default: '0};
			dupVld_r <= '0;
			dupPtr_r <= DUP_PTR_RST;
		end else begin
			dupOrig_r <= dupOrig_nxt;
			dupFid_r <= dupFid_nxt;
			dupVld_r <= dupVld_nxt;
			dupPtr_r <= dupPtr_nxt;
		end
	end

	// ****************************************
	// Frame engine
	// ****************************************
	always_comb begin
		state_nxt = state_r;
		hdr_nxt = hdr_r;
		isOrig_nxt = isOrig_r;
		txFlag_nxt = txFlag_r;
		rxHops_nxt = rxHops_r;
		upSrc_nxt = upSrc_r;
		drop_nxt = 1'b0;
		refused_nxt = 1'b0;
		dupRec = 1'b0;
		ackSend_nxt = 1'b0;
		{ackKind_nxt, ackOk_nxt, ackMap_nxt, ackDest_nxt} = {ackKind, ackOk, ackMap, ackDest};
		case (state_r)
			ST_IDLE: begin
				if (rxValid) begin
					hdr_nxt = '{addrMode: rxMesh ? MODE_SHORT : MODE_NONE, hopsLeft: rxHopsLeft,
						origAddr: rxOrigAddr, finalAddr: rxFinalAddr, srcNode: rxSrcNode,
						dstNode: rxDstNode, fid: rxFid, ackReq: rxAckReq, ackType: rxAckType};
					rxHops_nxt = rxHopsLeft;
					upSrc_nxt = rxSrcNode;
					isOrig_nxt = 1'b0;
					txFlag_nxt = 1'b0;
					if (rxAckReq && rxDstNode == ownId) begin
						ackSend_nxt = 1'b1;
						ackKind_nxt = rxAckType;
						ackOk_nxt = rxCrcOk;
						ackMap_nxt = rxAckType ? rxErrMap : '0;
						ackDest_nxt = rxSrcNode;
					end
					if (rxMesh) begin
						state_nxt = ST_LOOK;
					end else if (rxDstNode == ownId || rxDstNode == ALL_NODES) begin
						state_nxt = ST_UP;
					end else begin
						drop_nxt = 1'b1;
					end
				end else if (origValid) begin
					isOrig_nxt = 1'b1;
					txFlag_nxt = 1'b1;
					if (origMulti && !relayEnable) begin
						refused_nxt = 1'b1;
					end else begin
						// Broadcasts never ask for an acknowledgement
						hdr_nxt = '{addrMode: origMulti ? MODE_SHORT : MODE_NONE,
							hopsLeft: maxHops,
							origAddr: ownId,
							finalAddr: origBcast ? ALL_NODES : origDest,
							srcNode: ownId,
							dstNode: origBcast ? ALL_NODES : origDest,
							fid: origFid, ackReq: origAckReq && !origBcast,
							ackType: origAckType};
						state_nxt = origMulti ? ST_LOOK : ST_TX;
					end
				end
			end
			ST_LOOK: begin
				if (lkAck) begin
					if (isOrig_r) begin
						hdr_nxt.dstNode = nextDst;
						hdr_nxt.ackReq = hdr_r.ackReq && (nextDst != ALL_NODES);
						state_nxt = ST_TX;
					end else if (hdr_r.finalAddr == ownId) begin
						if (lkSenderOk) begin
							state_nxt = ST_UP;
						end else begin
							drop_nxt = 1'b1;
							state_nxt = ST_IDLE;
						end
					end else begin
						hdr_nxt.hopsLeft = hdr_r.hopsLeft - HOP_ONE;
						hdr_nxt.srcNode = ownId;
						hdr_nxt.dstNode = nextDst;
						hdr_nxt.ackReq = hdr_r.ackReq && (nextDst != ALL_NODES);
						dupRec = doDeliver;
						txFlag_nxt = doRelay;
						drop_nxt = !doDeliver && !doRelay;
						if (doDeliver) begin
							state_nxt = ST_UP;
						end else if (doRelay) begin
							state_nxt = ST_TX;
						end else begin
							state_nxt = ST_IDLE;
						end
					end
				end
			end
			ST_UP: begin
				if (upReady) begin
					state_nxt = txFlag_r ? ST_TX : ST_IDLE;
				end
			end
			ST_TX: begin
				if (fifoIf.inRdy) begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			hdr_r <= '0;
			{isOrig_r, txFlag_r, rxHops_r, upSrc_r} <= '0;
			{dropPulse, origRefused} <= '0;
			{ackSend, ackKind, ackOk, ackMap, ackDest} <= '0;
		end else begin
			state_r <= state_nxt;
			hdr_r <= hdr_nxt;
			{isOrig_r, txFlag_r} <= {isOrig_nxt, txFlag_nxt};
			{rxHops_r, upSrc_r} <= {rxHops_nxt, upSrc_nxt};
			{dropPulse, origRefused} <= {drop_nxt, refused_nxt};
			{ackSend, ackKind, ackOk} <= {ackSend_nxt, ackKind_nxt, ackOk_nxt};
			{ackMap, ackDest} <= {ackMap_nxt, ackDest_nxt};
		end
	end
	// ****************************************
	// Retransmit decision
	// ****************************************
	always_comb begin
		retxValid_nxt = ackInValid && (ackInKind ? (ackInMap != '0) : !ackInOk);
		retxWhole_nxt = ackInValid && !ackInKind && !ackInOk;
		retxMap_nxt = (ackInValid && ackInKind) ? ackInMap : '0;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{retxValid, retxWhole, retxMap} <= '0;
		end else begin
			{retxValid, retxWhole, retxMap} <= {retxValid_nxt, retxWhole_nxt, retxMap_nxt};
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	AST_MODE_SET: assert property (origValid && origReady && origMulti && relayEnable
		|=> hdr_r.addrMode == MODE_SHORT) else $error("origin address mode not 11");
	AST_ORIG_HOPS: assert property (origValid && origReady && origMulti && relayEnable
		|=> hdr_r.hopsLeft == $past(maxHops)) else $error("origin hop count wrong");
	AST_ORIG_ADDR: assert property (origValid && origReady && !origBcast && relayEnable
		|=> hdr_r.origAddr == $past(ownId) && hdr_r.finalAddr == $past(origDest))
		else $error("unicast origin addresses wrong");
	AST_BC_FINAL: assert property (origValid && origReady && origBcast && relayEnable
		|=> hdr_r.finalAddr == ALL_NODES && hdr_r.origAddr == $past(ownId))
		else $error("broadcast origin addresses wrong");
	AST_HOP_DEC: assert property (push && !isOrig_r
		|-> hdr_r.hopsLeft == rxHops_r - HOP_ONE) else $error("relay hop count not decremented");
	AST_ZERO_DROP: assert property (push && !isOrig_r |-> rxHops_r != '0)
		else $error("zero hop frame relayed");
	AST_RELAY_EN: assert property (push && (!isOrig_r || hdr_r.addrMode == MODE_SHORT)
		|-> relayEnable) else $error("relaying while disabled");
	AST_ACK_REQ: assert property (ackSend |-> $past(rxValid && rxReady && rxAckReq))
		else $error("acknowledgement without request");
	AST_BC_DST: assert property (push && hdr_r.addrMode == MODE_NONE
		&& hdr_r.finalAddr == ALL_NODES |-> hdr_r.dstNode == ALL_NODES)
		else $error("single-hop broadcast destination wrong");
	AST_RETX: assert property (ackInValid && !ackInKind && !ackInOk
		|=> retxValid && retxWhole) else $error("negative acknowledgement not retransmitted");
	AST_DEST_DROP: assert property (lkReq && lkAck && !isOrig_r
		&& hdr_r.finalAddr == ownId && !lkSenderOk |=> dropPulse && state_r == ST_IDLE)
		else $error("destination frame with bad sender not dropped");
	AST_DUP: assert property (lkReq && lkAck && !isOrig_r && lkBcast
		&& hdr_r.finalAddr != ownId && dupHit |=> state_r == ST_IDLE ##1 !upValid)
		else $error("broadcast copy delivered or relayed again");
	CV_RELAY: cover property (push && !isOrig_r);
	CV_BC_UP: cover property (upValid && upReady && lkBcast ##[1:3] push);
	CV_ACK: cover property (ackSend && ackKind);
	CV_REFUSE: cover property (origRefused);
endmodule

// *** inc/mesh_relay_pkg.sv ***
/*
 * Constants, header layout and states of the mesh relay block.
 * Assumes one clock domain; imported by the relay top and the bench, the top sizes its FIFO from it.
 */
package mesh_relay_pkg;
	localparam int ID_W = 16;
	localparam int HOP_W = 4;
	localparam int FID_W = 8;
	localparam int MAP_W = 8;
	localparam int FIFO_DEPTH = 16;
	localparam int DUP_N = 4;
	localparam logic [ID_W-1:0] ALL_NODES = 16'hffff;
	localparam logic [1:0] MODE_SHORT = 2'h3;
	localparam logic [1:0] MODE_NONE = 2'h0;
	localparam logic [HOP_W-1:0] HOP_ONE = 4'h1;
	localparam logic [1:0] DUP_PTR_RST = 2'h0;

	typedef struct packed {
		logic [1:0]       addrMode;
		logic [HOP_W-1:0] hopsLeft;
		logic [ID_W-1:0]  origAddr;
		logic [ID_W-1:0]  finalAddr;
		logic [ID_W-1:0]  srcNode;
		logic [ID_W-1:0]  dstNode;
		logic [FID_W-1:0] fid;
		logic             ackReq;
		logic             ackType;
	} txd_t;

	localparam int TXD_W = $bits(txd_t);

	typedef enum logic [1:0] {ST_IDLE, ST_LOOK, ST_UP, ST_TX} state_t;
endpackage

// *** inc/fifo_if.sv ***
/*
 * Valid/ready carrier between the relay engine and its transmit FIFO.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ns
interface fifo_if #(parameter int W = 8);
	logic         inVal;
	logic         inRdy;
	logic [W-1:0] inData;
	logic         outVal;
	logic         outRdy;
	logic [W-1:0] outData;

	modport writer (output inVal, output inData, input inRdy);
	modport store  (input inVal, input inData, output inRdy,
	                output outVal, output outData, input outRdy);
	modport reader (input outVal, input outData, output outRdy);
endinterface

// *** hw/relay_fifo.sv ***
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two and WIDTH matches the carrier width.
 */
`timescale 1ns/1ns
module relay_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	fifo_if.store    q
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wrPtr_r;
	logic [AW:0]      wrPtr_nxt;
	logic [AW:0]      rdPtr_r;
	logic [AW:0]      rdPtr_nxt;
	logic             full;
	logic             empty;
	logic             doWr;
	logic             doRd;

	// Extra pointer bit tells full from empty
	assign full = (wrPtr_r[AW] != rdPtr_r[AW]) && (wrPtr_r[AW-1:0] == rdPtr_r[AW-1:0]);
	assign empty = (wrPtr_r == rdPtr_r);
	assign doWr = q.inVal && !full;
	assign doRd = q.outRdy && !empty;
	assign q.inRdy = !full;
	assign q.outVal = !empty;
	assign q.outData = mem[rdPtr_r[AW-1:0]];

	always_comb begin
		wrPtr_nxt = wrPtr_r + (AW+1)'(doWr);
		rdPtr_nxt = rdPtr_r + (AW+1)'(doRd);
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
		end else begin
			wrPtr_r <= wrPtr_nxt;
			rdPtr_r <= rdPtr_nxt;
		end
	end

	// Storage carries no reset; empty flag masks stale words
	always_ff @(posedge ref_clk) begin
		if (doWr) begin
			mem[wrPtr_r[AW-1:0]] <= q.inData;
		end
	end
endmodule

// *** verif/db_model.sv ***
/*
 * Relaying database stand-in that answers lookups of the relay engine.
 * Assumes the bench sets the answer fields and the wait before each frame.
 */
`timescale 1ns/1ns
module db_model (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        lkReq,
	input  wire logic [1:0]  dbWait,
	input  wire logic        dbSender,
	input  wire logic        dbPath,
	input  wire logic        dbBcast,
	input  wire logic [15:0] dbHop,
	output wire logic        lkAck,
	output wire logic        lkSenderOk,
	output wire logic        lkPathOk,
	output wire logic [15:0] lkNextHop,
	output wire logic        lkUseBcast
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;

	// Answer after dbWait cycles; zero answers in the request cycle
	assign lkAck = lkReq && cnt_r == dbWait;
	// Outside the answer cycle the lines carry the inverse, never stale data
	assign lkSenderOk = lkAck ? dbSender : !dbSender;
	assign lkPathOk = lkAck ? dbPath : !dbPath;
	assign lkNextHop = lkAck ? dbHop : ~dbHop;
	assign lkUseBcast = lkAck ? dbBcast : !dbBcast;

	always_comb begin
		cnt_nxt = (!lkReq || lkAck) ? 2'h0 : cnt_r + 2'h1;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= 2'h0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// *** verif/tb_mesh_frame_relay_logic.sv ***
/*
 * Self-checking bench of the mesh relay engine with a database model.
 * Assumes inputs change 10 ns after the rising edge; pulses seen at negedge.
 */
`timescale 1ns/1ns
module tb_mesh_frame_relay_logic;
	import mesh_relay_pkg::*;
	logic ref_clk = 0, rst_n = 0, relayEnable = 1, isRelay = 1, isBcastRelay = 0;
	logic [15:0] ownId = 16'h0012, dbHop = 16'h0034, origDest = 0;
	logic [15:0] rxSrcNode = 0, rxDstNode = 0, rxOrigAddr = 0, rxFinalAddr = 0;
	logic [3:0] maxHops = 4'h7, rxHopsLeft = 0;
	logic [7:0] rxFid = 0, rxErrMap = 0, origFid = 0, ackInMap = 0;
	logic rxValid = 0, rxMesh = 0, rxAckReq = 0, rxAckType = 0, rxCrcOk = 1;
	logic origValid = 0, origMulti = 0, origBcast = 0, origAckReq = 0, origAckType = 0;
	logic upReady = 1, txReady = 1, ackInValid = 0, ackInKind = 0, ackInOk = 0;
	logic [1:0] dbWait = 0;
	logic dbSender = 1, dbPath = 1, dbBcast = 0;
	wire logic rxReady, origReady, origRefused, lkReq, lkBcast, lkAck, lkSenderOk;
	wire logic lkPathOk, lkUseBcast, upValid, upMesh, txValid, ackSend, ackKind, ackOk;
	wire logic retxValid, retxWhole, dropPulse;
	wire logic [15:0] lkSrcNode, lkOrigAddr, lkFinalAddr, lkNextHop, ackDest;
	wire logic [15:0] upSrcNode, upOrigAddr, upFinalAddr;
	wire logic [7:0] upFid, ackMap, retxMap;
	wire txd_t txHeader;
	logic [7:0] ups, drops, acks, refs, retxs, lastMap;
	logic [25:0] lastAck;
	logic [56:0] lastUp;
	logic [47:0] lastLk;
	logic lastWhole;
	txd_t txq[$];
	txd_t h;
	int cycles = 0, bad_count = 0, num_checks = 0, k;

	always #50 ref_clk = ~ref_clk;
	mesh_frame_relay_logic u_mesh_frame_relay_logic (.*);
	db_model u_db_model (.*);

	/*************/
	/* Monitors  */
	/*************/
	always @(negedge ref_clk) begin
		if (dropPulse === 1'b1) drops++;
		if (origRefused === 1'b1) refs++;
		if (lkAck === 1'b1) lastLk = {lkSrcNode, lkOrigAddr, lkFinalAddr};
		if (ackSend === 1'b1) begin
			acks++;
			lastAck = {ackKind, ackOk, ackMap, ackDest};
		end
		if (retxValid === 1'b1) begin
			retxs++;
			lastWhole = retxWhole;
			lastMap = retxMap;
		end
		if (upValid === 1'b1 && upReady === 1'b1) begin
			ups++;
			lastUp = {upMesh, upSrcNode, upOrigAddr, upFinalAddr, upFid};
		end
		if (txValid === 1'b1 && txReady === 1'b1) txq.push_back(txHeader);
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			complete_run;
		end
	end

	/*************/
	/* Tasks     */
	/*************/
	task automatic check(input string n, input logic [TXD_W-1:0] s, input logic [TXD_W-1:0] e);
		num_checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task complete_run;
		if (bad_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	task tick;
		@(posedge ref_clk);
		#10;
	endtask

	task clr;
		{ups, drops, acks, refs, retxs} = 40'h0;
		txq.delete();
	endtask

	// Engine back in idle and FIFO drained, then room for pulses
	task automatic settle;
		int i;
		for (i = 0; i < 60 && (rxReady !== 1'b1 || txValid === 1'b1); i++) tick;
		repeat (4) tick;
	endtask

	task automatic cnt(input logic [7:0] u, d, a, r, x, t);
		settle;
		check("counts", TXD_W'({ups, drops, acks, refs, retxs, 8'(txq.size())}),
		      TXD_W'({u, d, a, r, x, t}));
	endtask

	task automatic orig(input logic m, b, input logic [15:0] d, input logic [7:0] f,
	                    input logic a);
		int i;
		{origMulti, origBcast, origDest, origFid, origAckReq} = {m, b, d, f, a};
		origValid = 1;
		for (i = 0; i < 60 && origReady !== 1'b1; i++) tick;
		tick;
		origValid = 0;
	endtask

	task automatic rx(input logic m, input logic [15:0] s, d, o, fn, input logic [3:0] hp,
	                  input logic [7:0] f, input logic a, t);
		int i;
		{rxMesh, rxSrcNode, rxDstNode, rxOrigAddr, rxFinalAddr} = {m, s, d, o, fn};
		{rxHopsLeft, rxFid, rxAckReq, rxAckType} = {hp, f, a, t};
		rxValid = 1;
		for (i = 0; i < 60 && rxReady !== 1'b1; i++) tick;
		tick;
		rxValid = 0;
	endtask

	task automatic chk_tx(input txd_t e, input logic full);
		h = txq.pop_front();
		if (full) check("txHeader", h, e);
		else check("txFields", TXD_W'({h.hopsLeft, h.origAddr, h.finalAddr, h.srcNode,
		           h.dstNode}), TXD_W'({e.hopsLeft, e.origAddr, e.finalAddr, e.srcNode, e.dstNode}));
	endtask

	/*************/
	/* Sequence  */
	/*************/
	initial begin
		repeat (10) tick;
		check("resetOut", TXD_W'({rxReady, upValid, txValid}), TXD_W'(3'h4));
		rst_n = 1;
		tick;
		clr;
		orig(1, 0, 16'h0056, 8'h01, 1);
		cnt(0, 0, 0, 0, 0, 1);
		chk_tx('{MODE_SHORT, 4'h7, ownId, 16'h0056, ownId, dbHop, 8'h01, 1'b1, 1'b0}, 1);
		dbBcast = 1;
		orig(1, 1, 16'h0000, 8'h02, 1);
		cnt(0, 0, 0, 0, 0, 1);
		chk_tx('{MODE_SHORT, 4'h7, ownId, ALL_NODES, ownId, ALL_NODES, 8'h02, 1'b0, 1'b0}, 1);
		orig(0, 1, 16'h0000, 8'h03, 0);
		cnt(0, 0, 0, 0, 0, 1);
		h = txq.pop_front();
		check("bcastDst", TXD_W'(h.dstNode), TXD_W'(ALL_NODES));
		relayEnable = 0;
		orig(1, 0, 16'h0056, 8'h04, 0);
		cnt(0, 0, 0, 1, 0, 0);
		rx(1, 16'h0040, ownId, 16'h0050, 16'h0060, 4'h5, 8'h04, 0, 0);
		cnt(0, 1, 0, 1, 0, 0);
		clr;
		{relayEnable, dbBcast, dbWait} = {1'b1, 1'b0, 2'h3};
		rx(1, 16'h0040, ownId, 16'h0050, 16'h0060, 4'h5, 8'h04, 0, 0);
		cnt(0, 0, 0, 0, 0, 1);
		chk_tx('{MODE_SHORT, 4'h4, 16'h0050, 16'h0060, ownId, dbHop, 8'h0, 1'b0, 1'b0}, 0);
		check("lkFields", TXD_W'(lastLk), TXD_W'({16'h0040, 16'h0050, 16'h0060}));
		rx(1, 16'h0040, ownId, 16'h0050, 16'h0060, 4'h0, 8'h05, 0, 0);
		cnt(0, 1, 0, 0, 0, 0);
		dbPath = 0;
		rx(1, 16'h0040, ownId, 16'h0050, 16'h0060, 4'h5, 8'h06, 0, 0);
		cnt(0, 2, 0, 0, 0, 0);
		{dbPath, isRelay, dbWait} = {1'b1, 1'b0, 2'h0};
		rx(1, 16'h0040, ownId, 16'h0050, 16'h0060, 4'h5, 8'h07, 0, 0);
		cnt(0, 3, 0, 0, 0, 0);
		clr;
		rx(1, 16'h0040, ownId, 16'h0050, ownId, 4'h0, 8'h08, 0, 0);
		cnt(1, 0, 0, 0, 0, 0);
		dbSender = 0;
		rx(1, 16'h0040, ownId, 16'h0050, ownId, 4'h3, 8'h08, 0, 0);
		cnt(1, 1, 0, 0, 0, 0);
		clr;
		dbSender = 1;
		rx(1, 16'h0040, ALL_NODES, 16'h0070, ALL_NODES, 4'h3, 8'h09, 0, 0);
		cnt(1, 0, 0, 0, 0, 0);
		check("upFld", TXD_W'(lastUp), TXD_W'({1'b1, 16'h0040, 16'h0070, ALL_NODES, 8'h09}));
		rx(1, 16'h0040, ALL_NODES, 16'h0070, ALL_NODES, 4'h3, 8'h09, 0, 0);
		cnt(1, 1, 0, 0, 0, 0);
		dbPath = 0;
		rx(1, 16'h0040, ALL_NODES, 16'h0070, ALL_NODES, 4'h3, 8'h0c, 0, 0);
		cnt(1, 2, 0, 0, 0, 0);
		clr;
		{dbPath, isBcastRelay, dbBcast} = 3'h7;
		rx(1, 16'h0040, ALL_NODES, 16'h0071, ALL_NODES, 4'h3, 8'h0a, 0, 0);
		cnt(1, 0, 0, 0, 0, 1);
		chk_tx('{MODE_SHORT, 4'h2, 16'h0071, ALL_NODES, ownId, ALL_NODES, 8'h0, 1'b0, 1'b0}, 0);
		rx(1, 16'h0040, ALL_NODES, 16'h0071, ALL_NODES, 4'h3, 8'h0a, 0, 0);
		cnt(1, 1, 0, 0, 0, 0);
		clr;
		rxErrMap = 8'h0a;
		rx(0, 16'h0040, ownId, 16'h0000, 16'h0000, 4'h0, 8'h0b, 1, 1);
		cnt(1, 0, 1, 0, 0, 0);
		check("ackFields", TXD_W'(lastAck), TXD_W'({1'b1, 1'b1, 8'h0a, 16'h0040}));
		rx(0, 16'h0040, ownId, 16'h0000, 16'h0000, 4'h0, 8'h0d, 0, 0);
		cnt(2, 0, 1, 0, 0, 0);
		for (k = 0; k < 4; k++) begin
			clr;
			{ackInKind, ackInOk, ackInMap} = {k[1], k[0], (k == 2) ? 8'h05 : 8'h00};
			ackInValid = 1;
			tick;
			ackInValid = 0;
			cnt(0, 0, 0, 0, {7'h0, !k[0]}, 0);
			if (k == 0) check("retxWhole", TXD_W'(lastWhole), TXD_W'(1'b1));
			if (k == 2) check("retxMap", TXD_W'(lastMap), TXD_W'(8'h05));
		end
		// Far side stalls: 16 headers fill the FIFO, the 17th holds the engine
		clr;
		txReady = 0;
		for (k = 0; k < 17; k++) begin
			orig(0, 0, 16'h0099, 8'(k), 0);
			tick;
		end
		repeat (5) tick;
		check("fullStall", TXD_W'({origReady, txValid}), TXD_W'(2'h1));
		txReady = 1;
		cnt(0, 0, 0, 0, 0, 17);
		for (k = 0; k < 17; k++) check("fifoOrder", TXD_W'(txq[k].fid), TXD_W'(8'(k)));
		complete_run;
	end
endmodule
